// ---- inc/pcas_consts.vh ----
// constants for the attribute-memory and configuration register port
`ifndef PCAS_CONSTS_VH
`define PCAS_CONSTS_VH
`define PCAS_EXT_TOP 16'h7FFE
`define PCAS_OPT_OFS 16'h8000
`define PCAS_STAT_OFS 16'h8002
`define PCAS_CFG_TOP 16'h8003
`define PCAS_OPT_SOFT_RESET_BIT 7
`define PCAS_OPT_LEVIRQ 6
`define PCAS_OPT_PERMIT 2
`define PCAS_OPT_ENABLE 0
`define PCAS_STAT_BYTE 5
`define PCAS_STAT_PWRDN 2
`define PCAS_STAT_INTR 1
`define PCAS_OPT_RESET 8'h40
`define PCAS_STAT_RESET 8'h00
`define PCAS_OPT_WMASK 8'h85
`define PCAS_STAT_WMASK 8'h24
`define PCAS_SYNC_W 25
`endif

// ---- core/pcas_sync.v ----
// two-flop synchroniser for the host socket pins
`timescale 1ns/100ps
module pcas_sync #(
    parameter W = 25
) (
    input wire core_clk,
    input wire srst,
    input wire [W-1:0] async_in,
    input wire [W-1:0] reset_val,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] stage1;

    // first stage feeds only the second stage
    always @(posedge core_clk) begin
        if (srst) begin
            stage1 <= reset_val;
            sync_out <= reset_val;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ---- core/pcas_attr_port.v ----
// attribute-memory decode, external store strobes and function configuration registers
`timescale 1ns/100ps
`include "pcas_consts.vh"
// Summary of operation
// - lower attribute range goes to the external store via select and write strobes
// - data bus drivers stay off during external store accesses
// - decode uses even locations; 8000h-8003h (A9-A2 zero, A15 high) selects the internal registers
// - configuration registers are eight bits wide on even addresses only
// - odd accesses to configuration area discard writes and read zero
// - decode uses address bits 0-9, bit 15, register select, card enable, strobes
// - every attribute read with address bit 0 high returns zero
// - soft reset clears the status register and lowers ready pin until cleared
// - level interrupt indicator is read-only and always reads one
// - external store writes happen only while the write permit bit is set
// - function enable low holds power down and blocks the I/O banks
// - function disabled means no interrupt request and no input acknowledge
// - wake setting has no effect while the function is disabled
// - host byte-only bit forces byte mode over strap and wide setting
// - host byte-only bit floats the 16-bit I/O indication output
// - power-down bit or cleared enable puts the function in power down
// - interrupt bit reads one on service request and drives the request output
// - hard reset clears both registers except the level indicator
// - power-down pin powers everything down and asserts modem sleep output
module pcas_attr_port (
    input wire core_clk,
    input wire srst,
    input wire [9:0] host_addr_low,
    input wire host_addr_15,
    input wire host_reg_n,
    input wire host_ce1_n,
    input wire host_we_n,
    input wire host_oe_n,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output wire host_data_oe,
    output reg attr_store_select_n,
    output reg attr_store_write_n,
    input wire power_down_pin,
    input wire wide_bus_strap_n,
    input wire wide_bus_setting,
    input wire func_service_req,
    input wire func_io_access,
    input wire func_io_is16_req,
    input wire wake_setting,
    output wire irq_ready_n,
    output wire service_request_output,
    output wire func_soft_reset,
    output wire func_power_down,
    output wire func_io_enable,
    output wire input_ack,
    output wire wake_enable,
    output wire host_byte_only,
    output wire func_wide_mode,
    output wire io_is16_out,
    output wire io_is16_oe,
    output wire modem_sleep_output_n
);
    localparam ST_IDLE = 2'b00;
    localparam ST_EXT = 2'b01;
    localparam ST_CFG = 2'b10;
    localparam ST_DONE = 2'b11;

    wire [`PCAS_SYNC_W-1:0] pin_raw;
    wire [`PCAS_SYNC_W-1:0] pin_rst;
    wire [`PCAS_SYNC_W-1:0] pin_s;
    wire [9:0] a_s;
    wire a15_s;
    wire reg_n_s;
    wire ce1_n_s;
    wire we_n_s;
    wire oe_n_s;
    wire [7:0] d_s;
    wire pdpin_s;
    wire strap_n_s;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] opt_reg;
    reg [7:0] stat_reg;
    reg [9:0] lat_addr;
    reg lat_a15;
    reg [7:0] lat_data;
    reg we_seen;
    wire cycle_on;
    wire cfg_hit;
    wire ext_hit;
    wire odd_acc;
    wire commit;
    wire [7:0] stat_view;
    reg [7:0] next_rdata;
    reg [7:0] next_opt_reg;
    reg [7:0] next_stat_reg;
    reg next_store_select_n;
    reg next_store_write_n;
    wire [7:0] opt_wmask;
    wire [7:0] stat_wmask;
    wire [7:0] opt_fixed;
    wire [7:0] opt_wr_val;
    wire [7:0] stat_wr_val;
    genvar gi;

    assign pin_raw = {host_addr_low, host_addr_15, host_reg_n, host_ce1_n, host_we_n, host_oe_n,
                      host_data_in, power_down_pin, wide_bus_strap_n};
    // strobes and strap idle high
    assign pin_rst = {10'h000, 1'b0, 4'hF, 8'h00, 1'b0, 1'b1};

    pcas_sync #(
        .W(`PCAS_SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(pin_raw),
        .reset_val(pin_rst),
        .sync_out(pin_s)
    );

    assign {a_s, a15_s, reg_n_s, ce1_n_s, we_n_s, oe_n_s, d_s, pdpin_s, strap_n_s} = pin_s;

    // a decode over A9-A2 and A15 only
    function [1:0] attr_decode;
        input [9:0] a;
        input a15;
        begin
            if (!a15) begin
                attr_decode = 2'b01;
            end else if (a[9:2] == 8'h00) begin
                attr_decode = 2'b10;
            end else begin
                attr_decode = 2'b00;
            end
        end
    endfunction

    // picks the status register inside the configuration area
    function cfg_is_status;
        input [9:0] a;
        begin
            cfg_is_status = a[1];
        end
    endfunction

    // attribute cycle: register space, card enable, a strobe, pin not asserted
    assign cycle_on = !reg_n_s && !ce1_n_s && (!we_n_s || !oe_n_s) && !pdpin_s;
    assign ext_hit = attr_decode(a_s, a15_s) == 2'b01;
    assign cfg_hit = attr_decode(a_s, a15_s) == 2'b10;
    assign odd_acc = a_s[0];

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cycle_on && ext_hit && !odd_acc) begin
                    next_state = ST_EXT;
                end else if (cycle_on) begin
                    next_state = ST_CFG;
                end
            end
            ST_EXT: begin
                if (!cycle_on) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CFG: begin
                if (!cycle_on) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // hold address and write data while the strobes are active
    always @(posedge core_clk) begin
        if (srst) begin
            lat_addr <= 10'h000;
            lat_a15 <= 1'b0;
            lat_data <= 8'h00;
            we_seen <= 1'b0;
        end else if (cycle_on) begin
            lat_addr <= a_s;
            lat_a15 <= a15_s;
            if (!we_n_s) begin
                lat_data <= d_s;
                we_seen <= 1'b1;
            end
        end else if (state == ST_DONE || state == ST_IDLE) begin
            we_seen <= 1'b0;
        end
    end

    // the write lands when the strobe ends; odd or unmapped writes are dropped
    assign commit = state == ST_DONE && we_seen && !lat_addr[0] &&
                    attr_decode(lat_addr, lat_a15) == 2'b10;

    assign opt_wmask = `PCAS_OPT_WMASK;
    assign stat_wmask = `PCAS_STAT_WMASK;
    assign opt_fixed = `PCAS_OPT_RESET;

    // writable bits take the host byte; read-only and undefined bits keep their fixed level
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_cfg_bit
            assign opt_wr_val[gi] = opt_wmask[gi] ? lat_data[gi] : opt_fixed[gi];
            assign stat_wr_val[gi] = stat_wmask[gi] & lat_data[gi];
        end
    endgenerate

    always @* begin
        next_opt_reg = opt_reg;
        next_stat_reg = stat_reg;
        if (commit && !cfg_is_status(lat_addr)) begin
            next_opt_reg = opt_wr_val;
        end
        if (opt_reg[`PCAS_OPT_SOFT_RESET_BIT]) begin
            next_stat_reg = `PCAS_STAT_RESET;
        end else if (commit && cfg_is_status(lat_addr)) begin
            next_stat_reg = stat_wr_val;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            opt_reg <= `PCAS_OPT_RESET;
            stat_reg <= `PCAS_STAT_RESET;
        end else begin
            opt_reg <= next_opt_reg;
            stat_reg <= next_stat_reg;
        end
    end

    // interrupt bit reflects the live request of the function
    assign stat_view = {stat_reg[7:2], func_service_req, stat_reg[0]};

    always @* begin
        next_rdata = 8'h00;
        if (cycle_on && cfg_hit && !odd_acc) begin
            if (cfg_is_status(a_s)) begin
                next_rdata = stat_view;
            end else begin
                next_rdata = opt_reg;
            end
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            host_data_out <= 8'h00;
        end else begin
            host_data_out <= next_rdata;
        end
    end

    // drive only during our own read cycles, never for the external store
    assign host_data_oe = (state == ST_CFG) && cycle_on && !oe_n_s;

    always @* begin
        next_store_select_n = 1'b1;
        next_store_write_n = 1'b1;
        if (next_state == ST_EXT) begin
            next_store_select_n = 1'b0;
            if (!we_n_s && opt_reg[`PCAS_OPT_PERMIT]) begin
                next_store_write_n = 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            attr_store_select_n <= 1'b1;
            attr_store_write_n <= 1'b1;
        end else begin
            attr_store_select_n <= next_store_select_n;
            attr_store_write_n <= next_store_write_n;
        end
    end

    assign func_soft_reset = opt_reg[`PCAS_OPT_SOFT_RESET_BIT];
    assign irq_ready_n = !opt_reg[`PCAS_OPT_SOFT_RESET_BIT];
    assign func_power_down = pdpin_s || !opt_reg[`PCAS_OPT_ENABLE] || stat_reg[`PCAS_STAT_PWRDN];
    assign func_io_enable = opt_reg[`PCAS_OPT_ENABLE] && !pdpin_s;
    assign input_ack = func_io_access && func_io_enable;
    assign service_request_output = func_service_req && func_io_enable;
    assign wake_enable = wake_setting && opt_reg[`PCAS_OPT_ENABLE];
    assign host_byte_only = stat_reg[`PCAS_STAT_BYTE];
    assign func_wide_mode = !host_byte_only && !strap_n_s && wide_bus_setting;
    assign io_is16_out = func_io_is16_req;
    assign io_is16_oe = func_io_is16_req && !host_byte_only;
    assign modem_sleep_output_n = !pdpin_s;
endmodule

// ---- dv/pcas_store_model.sv ----
// behavioural external attribute store on the card side
`timescale 1ns/100ps
module pcas_store_model (
    input wire select_n,
    input wire write_n,
    input wire read_n,
    input wire [9:0] addr,
    input wire [7:0] din,
    output wire [7:0] dout,
    output wire dout_oe
);
    reg [7:0] mem [0:511];
    assign dout_oe = !select_n && !read_n;
    assign dout = mem[addr[9:1]];
    // even locations only; a byte lands when the write strobe ends
    always @(posedge write_n) begin
        mem[addr[9:1]] <= din;
    end
endmodule

// ---- dv/pcas_attr_port_monitor.sv ----
// assertion checker for the attribute port
`timescale 1ns/100ps
module pcas_monitor (
    input wire core_clk,
    input wire srst,
    input wire [9:0] host_addr_low,
    input wire [7:0] host_data_out,
    input wire host_data_oe,
    input wire attr_store_select_n,
    input wire attr_store_write_n,
    input wire power_down_pin,
    input wire func_io_access,
    input wire irq_ready_n,
    input wire func_soft_reset,
    input wire func_power_down,
    input wire func_io_enable,
    input wire input_ack,
    input wire host_byte_only,
    input wire func_wide_mode,
    input wire io_is16_oe,
    input wire modem_sleep_output_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_store_tristate: assert property (!attr_store_select_n |-> !host_data_oe)
        else $error("data bus driven during store access");
    a_store_write: assert property (!attr_store_write_n |-> !attr_store_select_n)
        else $error("store write without select");
    a_byte_float: assert property (host_byte_only |-> !io_is16_oe && !func_wide_mode)
        else $error("byte-only host not honoured");
    a_ack_gate: assert property (input_ack == (func_io_access && func_io_enable))
        else $error("input ack wrong");
    a_soft_ready: assert property (irq_ready_n == !func_soft_reset)
        else $error("ready pin not tied to soft reset");
    a_pin_sleep: assert property (power_down_pin [*2] |=> !modem_sleep_output_n && func_power_down)
        else $error("pin power down missed");
    a_reset_vals: assert property ($past(srst) |-> attr_store_select_n && attr_store_write_n && irq_ready_n
        && !host_data_oe && !host_byte_only)
        else $error("reset state wrong");
    a_odd_zero: assert property (host_addr_low[0] [*4] ##0 host_data_oe |-> host_data_out == 8'h00)
        else $error("odd read not zero");
endmodule
bind pcas_attr_port pcas_monitor u_mon (.core_clk(core_clk), .srst(srst), .host_addr_low(host_addr_low),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .attr_store_select_n(attr_store_select_n),
    .attr_store_write_n(attr_store_write_n), .power_down_pin(power_down_pin), .func_io_access(func_io_access),
    .irq_ready_n(irq_ready_n), .func_soft_reset(func_soft_reset), .func_power_down(func_power_down),
    .func_io_enable(func_io_enable), .input_ack(input_ack), .host_byte_only(host_byte_only),
    .func_wide_mode(func_wide_mode), .io_is16_oe(io_is16_oe), .modem_sleep_output_n(modem_sleep_output_n));

// ---- dv/test_pcmcia_attribute_config_space.sv ----
// self-checking bench for the attribute port
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_pcmcia_attribute_config_space;
    reg core_clk = 0, srst = 1, host_addr_15 = 0, host_reg_n = 1, host_ce1_n = 1, host_we_n = 1, host_oe_n = 1;
    reg power_down_pin = 0, wide_bus_strap_n = 0, wide_bus_setting = 1, func_service_req = 0, func_io_access = 1;
    reg func_io_is16_req = 1, wake_setting = 1, drv = 0;
    reg [9:0] host_addr_low = 0;
    reg [7:0] tdat = 0, cyc = 0, q;
    int fail_count = 0, cmp_count = 0;
    wire [7:0] host_data_in, host_data_out, st_q;
    wire host_data_oe, attr_store_select_n, attr_store_write_n, st_oe, irq_ready_n, service_request_output;
    wire func_soft_reset, func_power_down, func_io_enable, input_ack, wake_enable, host_byte_only;
    wire func_wide_mode, io_is16_out, io_is16_oe, modem_sleep_output_n;
    // undriven bus shows a changing pattern
    assign host_data_in = host_data_oe ? host_data_out : st_oe ? st_q : drv ? tdat : ~cyc;
    pcas_attr_port dut (.core_clk(core_clk), .srst(srst), .host_addr_low(host_addr_low),
        .host_addr_15(host_addr_15), .host_reg_n(host_reg_n), .host_ce1_n(host_ce1_n), .host_we_n(host_we_n),
        .host_oe_n(host_oe_n), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .attr_store_select_n(attr_store_select_n),
        .attr_store_write_n(attr_store_write_n),
        .power_down_pin(power_down_pin), .wide_bus_strap_n(wide_bus_strap_n), .wide_bus_setting(wide_bus_setting),
        .func_service_req(func_service_req), .func_io_access(func_io_access), .func_io_is16_req(func_io_is16_req),
        .wake_setting(wake_setting), .irq_ready_n(irq_ready_n), .service_request_output(service_request_output),
        .func_soft_reset(func_soft_reset), .func_power_down(func_power_down), .func_io_enable(func_io_enable),
        .input_ack(input_ack), .wake_enable(wake_enable), .host_byte_only(host_byte_only),
        .func_wide_mode(func_wide_mode), .io_is16_out(io_is16_out), .io_is16_oe(io_is16_oe),
        .modem_sleep_output_n(modem_sleep_output_n));
    pcas_store_model u_store (.select_n(attr_store_select_n), .write_n(attr_store_write_n), .read_n(host_oe_n),
        .addr(host_addr_low), .din(host_data_in), .dout(st_q), .dout_oe(st_oe));
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 8'h01;
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task acc(input [15:0] a, input wr, input [7:0] d);
        @(posedge core_clk);
        host_addr_low <= a[9:0];
        host_addr_15 <= a[15];
        tdat <= d;
        drv <= wr;
        host_reg_n <= 0;
        host_ce1_n <= 0;
        @(posedge core_clk);
        host_we_n <= !wr;
        host_oe_n <= wr;
        repeat (6) @(posedge core_clk);
        q = host_data_in;
        host_we_n <= 1;
        host_oe_n <= 1;
        repeat (4) @(posedge core_clk);
        host_reg_n <= 1;
        host_ce1_n <= 1;
        @(posedge core_clk);
    endtask
    task rd(input [15:0] a, input [7:0] e);
        acc(a, 0, 8'h00);
        `CHK(q, e)
    endtask
    initial begin
        #100000;
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 0;
        rd(16'h8000, 8'h40);
        rd(16'h8002, 8'h00);
        `CHK(func_wide_mode, 1'b1)
        `CHK(io_is16_oe, 1'b1)
        acc(16'h8000, 1, 8'hFF);
        `CHK(irq_ready_n, 1'b0)
        rd(16'h8000, 8'hC5);
        acc(16'h8000, 1, 8'h05);
        `CHK(irq_ready_n, 1'b1)
        acc(16'h8001, 1, 8'h00);
        rd(16'h8001, 8'h00);
        rd(16'h8000, 8'h45);
        rd(16'h8010, 8'h00);
        acc(16'h0010, 1, 8'h3C);
        rd(16'h0010, 8'h3C);
        acc(16'h8000, 1, 8'h01);
        acc(16'h0010, 1, 8'h99);
        rd(16'h0010, 8'h3C);
        acc(16'h8002, 1, 8'hFF);
        func_service_req <= 1;
        rd(16'h8002, 8'h26);
        `CHK(({host_byte_only, func_wide_mode, io_is16_oe, func_power_down, service_request_output}), 5'b10011)
        `CHK(({wake_enable, input_ack, io_is16_out}), 3'b111)
        acc(16'h8002, 1, 8'h00);
        `CHK(func_power_down, 1'b0)
        acc(16'h8000, 1, 8'h00);
        `CHK(({func_power_down, func_io_enable, input_ack, service_request_output, wake_enable}), 5'b10000)
        power_down_pin <= 1;
        repeat (4) @(posedge core_clk);
        `CHK(modem_sleep_output_n, 1'b0)
        end_sim;
    end
endmodule
